// *** hdl/prm_map.svh ***
// Purpose: Constants for the bus request, reset and error pin steering
// Assumes: Included by the package and by every design module
// Notes: Positions index the synchroniser bank
`ifndef PRM_MAP_SVH
`define PRM_MAP_SVH
`define PRM_REQ_W 6
`define PRM_BASE_REQ 4
`define PRM_GNT_W 4
`define PRM_SYNC_W 12
`define PRM_SB_REQ 0
`define PRM_SB_GNT0 6
`define PRM_SB_RST 7
`define PRM_SB_SERR 8
`define PRM_SB_GPIO0 9
`define PRM_SB_HOST 10
`define PRM_SB_EXTARB 11
`define PRM_SYNC_RST 12'h1FF
`define PRM_STRAP_WAIT 2'h3
`endif

// *** hdl/prm_pkg.sv ***
// Purpose: Types shared by the pin steering modules
// Assumes: Constants come from prm_map.svh
// Notes: Mode is unset until the straps are taken after reset
`include "prm_map.svh"
package prm_pkg;
    typedef enum logic [1:0] {
        mode_unset,
        mode_host_int,
        mode_host_ext,
        mode_sat
    } prm_mode_e;
    typedef logic [`PRM_SYNC_W-1:0] prm_sync_t;
endpackage

// *** hdl/prm_sync_if.sv ***
// Purpose: Carries raw pin levels into the synchroniser and back out
// Assumes: One clock domain on the synchronised side
// Notes: Raw bits are asynchronous to clk
`timescale 1ns/1ps
interface prm_sync_if;
    import prm_pkg::*;
    prm_sync_t raw;
    prm_sync_t sync;
    modport bank (input raw, output sync);
    modport user (output raw, input sync);
endinterface

// *** hdl/prm_sync.sv ***
// Purpose: Two flip-flop synchroniser for every sampled pin
// Assumes: Reset value marks active-low pins idle high
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`include "prm_map.svh"
module prm_sync
    import prm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    prm_sync_if.bank port
);
    prm_sync_t meta_q;
    prm_sync_t sync_q;
    // Reset level per bit, taken bit by bit so no width is dropped
    localparam prm_sync_t rst_val = `PRM_SYNC_RST;

    // One pair of flops per bit
    genvar i;
    generate
        for (i = 0; i < `PRM_SYNC_W; i++) begin : g_bit
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q[i] <= rst_val[i];
                    sync_q[i] <= rst_val[i];
                end else begin
                    meta_q[i] <= port.raw[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign port.sync = sync_q;
endmodule

// *** hdl/prm_pin_mux.sv ***
// Purpose: Mode dependent steering of request, grant, reset, error pins
// Assumes: Straps are static; pins pass the synchroniser before use
// Notes: Outputs are registered; one cycle from cause to pin
// Contract
// - Internal arbiter mode: request lines 3-0 are inputs
// - External arbiter mode: request line 0 is output
// - External arbiter mode: request lines 3-1 driven high
// - Satellite mode: request line 0 asks for bus
// - Satellite mode: request line 1 is device select
// - Satellite mode: request lines 3-2 driven high
// - Alternate pins 24, 27 become requests 4, 5
// - Host mode: device drives bus reset output
// - Satellite mode: bus reset input starts warm reset
// - Pin 0 is general purpose or serial transmit
// - Internal arbiter mode: drive matching grant lines
`timescale 1ns/1ps
`include "prm_map.svh"
module prm_pin_mux
    import prm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic strap_host,
    input wire logic strap_ext_arb,
    input wire logic [`PRM_REQ_W-1:0] bus_request_lines_n_in,
    output logic [`PRM_REQ_W-1:0] bus_request_lines_n_out,
    output logic [`PRM_REQ_W-1:0] bus_request_lines_n_oe,
    input wire logic gpio_alt_req4,
    input wire logic gpio_alt_req5,
    output logic [`PRM_REQ_W-1:0] arb_request,
    input wire logic [`PRM_GNT_W-1:0] arb_grant,
    input wire logic bus_grant_line0_n_in,
    output logic [`PRM_GNT_W-1:0] bus_grant_lines_n_out,
    output logic [`PRM_GNT_W-1:0] bus_grant_lines_n_oe,
    input wire logic own_request,
    output logic own_granted,
    output logic config_device_select,
    input wire logic bus_reset_request,
    input wire logic bus_reset_line_n_in,
    output logic bus_reset_line_n_out,
    output logic bus_reset_line_n_oe,
    output logic warm_reset,
    input wire logic system_error_request,
    input wire logic system_error_line_n_in,
    output logic system_error_line_n_out,
    output logic system_error_line_n_oe,
    output logic system_error_seen,
    input wire logic gpio0_alt,
    input wire logic gpio0_out,
    input wire logic gpio0_oe,
    input wire logic serial0_transmit_out,
    input wire logic gpio0_pin_in,
    output logic gpio0_pin_out,
    output logic gpio0_pin_oe,
    output logic gpio0_in
);
    prm_sync_if sif ();
    prm_mode_e mode_q, mode_d;
    logic [1:0] wait_q;
    logic rst_prev_q;
    logic [`PRM_REQ_W-1:0] req_out_n_q, req_oe_q, arb_req_q;
    logic [`PRM_REQ_W-1:0] req_out_n_d, req_oe_d, arb_req_d, lane_en;
    logic [`PRM_GNT_W-1:0] gnt_out_n_q, gnt_oe_q, gnt_out_n_d, gnt_oe_d;
    logic own_gnt_q, cfg_sel_q, rst_out_n_q, rst_oe_q, warm_q;
    logic serr_oe_q, serr_seen_q, gp_out_q, gp_oe_q, gp_in_q;

    // Raw pin levels into the synchroniser bank
    assign sif.raw = {strap_ext_arb, strap_host, gpio0_pin_in,
                      system_error_line_n_in, bus_reset_line_n_in,
                      bus_grant_line0_n_in, bus_request_lines_n_in};

    prm_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .port(sif.bank)
    );

    // Synchronised views
    wire [`PRM_REQ_W-1:0] req_s = sif.sync[`PRM_SB_REQ +: `PRM_REQ_W];
    wire gnt0_s = sif.sync[`PRM_SB_GNT0];
    wire rst_s = sif.sync[`PRM_SB_RST];
    wire serr_s = sif.sync[`PRM_SB_SERR];
    wire gp_s = sif.sync[`PRM_SB_GPIO0];
    wire host_s = sif.sync[`PRM_SB_HOST];
    wire ext_s = sif.sync[`PRM_SB_EXTARB];

    // Mode decode
    wire m_int = (mode_q == mode_host_int);
    wire m_ext = (mode_q == mode_host_ext);
    wire m_sat = (mode_q == mode_sat);
    wire m_host = m_int | m_ext;
    wire m_set = m_host | m_sat;
    wire strap_take = (mode_q == mode_unset) && (wait_q == `PRM_STRAP_WAIT);
    assign mode_d = !host_s ? mode_sat :
                    (ext_s ? mode_host_ext : mode_host_int);

    // Straps taken once the synchroniser has settled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= mode_unset;
            wait_q <= 2'h0;
        end else if (strap_take) begin
            mode_q <= mode_d;
        end else if (mode_q == mode_unset) begin
            wait_q <= wait_q + 2'h1;
        end
    end

    // Which request lanes belong to the request set
    assign lane_en = {gpio_alt_req5, gpio_alt_req4, 4'hF};

    // Request lane steering per lane
    genvar i;
    generate
        for (i = 0; i < `PRM_REQ_W; i++) begin : g_req
            wire base = (i < `PRM_BASE_REQ);
            wire lane0 = (i == 0);
            wire sel_in = m_sat && (i == 1);
            assign arb_req_d[i] = m_int & lane_en[i] & ~req_s[i];
            assign req_oe_d[i] = (m_ext | m_sat) & lane_en[i] & ~sel_in
                                 & (base | ~lane0);
            assign req_out_n_d[i] = lane0 ? ~own_request : 1'b1;
        end
        for (i = 0; i < `PRM_GNT_W; i++) begin : g_gnt
            assign gnt_oe_d[i] = m_int | ((m_ext | m_sat) & (i != 0));
            assign gnt_out_n_d[i] = m_int ? ~arb_grant[i] : 1'b1;
        end
    endgenerate

    // Pin 0 selection between general purpose and serial transmit; warm reset edge detect
    wire gp_out_d = gpio0_alt ? serial0_transmit_out : gpio0_out;
    wire gp_oe_d = gpio0_alt | gpio0_oe;
    wire warm_d = m_sat & rst_prev_q & ~rst_s;

    // Output registers for request and grant lanes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            req_out_n_q <= '1;
            req_oe_q <= '0;
            arb_req_q <= '0;
            gnt_out_n_q <= '1;
            gnt_oe_q <= '0;
        end else begin
            req_out_n_q <= req_out_n_d;
            req_oe_q <= req_oe_d;
            arb_req_q <= arb_req_d;
            gnt_out_n_q <= gnt_out_n_d;
            gnt_oe_q <= gnt_oe_d;
        end
    end

    // Output registers for reset, error, select and pin 0
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            own_gnt_q <= 1'b0;
            cfg_sel_q <= 1'b0;
            rst_out_n_q <= 1'b1;
            rst_oe_q <= 1'b0;
            rst_prev_q <= 1'b1;
            warm_q <= 1'b0;
            serr_oe_q <= 1'b0;
            serr_seen_q <= 1'b0;
            gp_out_q <= 1'b0;
            gp_oe_q <= 1'b0;
            gp_in_q <= 1'b0;
        end else begin
            own_gnt_q <= (m_ext | m_sat) & ~gnt0_s;
            cfg_sel_q <= m_sat & req_s[1];
            rst_out_n_q <= ~(m_host & bus_reset_request);
            rst_oe_q <= m_host;
            rst_prev_q <= rst_s;
            warm_q <= warm_d;
            serr_oe_q <= m_set & system_error_request;
            serr_seen_q <= ~serr_s;
            gp_out_q <= gp_out_d;
            gp_oe_q <= gp_oe_d;
            gp_in_q <= gp_s;
        end
    end

    assign bus_request_lines_n_out = req_out_n_q;
    assign bus_request_lines_n_oe = req_oe_q;
    assign arb_request = arb_req_q;
    assign bus_grant_lines_n_out = gnt_out_n_q;
    assign bus_grant_lines_n_oe = gnt_oe_q;
    assign own_granted = own_gnt_q;
    assign config_device_select = cfg_sel_q;
    assign bus_reset_line_n_out = rst_out_n_q;
    assign bus_reset_line_n_oe = rst_oe_q;
    assign warm_reset = warm_q;
    assign system_error_line_n_out = 1'b0;
    assign system_error_line_n_oe = serr_oe_q;
    assign system_error_seen = serr_seen_q;
    assign gpio0_pin_out = gp_out_q;
    assign gpio0_pin_oe = gp_oe_q;
    assign gpio0_in = gp_in_q;

    // Checks on the steering
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_int_req_in: assert property ($past(m_int) |->
        req_oe_q[3:0] == 4'h0 && arb_req_q[0] == !$past(req_s[0]))
        else $error("request lanes not inputs in internal mode");
    a_ext_req0_out: assert property ($past(m_ext) |->
        req_oe_q[0] && req_out_n_q[0] == !$past(own_request))
        else $error("request 0 wrong in external mode");
    a_ext_spare_high: assert property ($past(m_ext) |->
        req_oe_q[3:1] == 3'h7 && req_out_n_q[3:1] == 3'h7)
        else $error("spare requests not high in external mode");
    a_sat_req0_out: assert property ($past(m_sat) && $past(own_request)
        |-> req_oe_q[0] && !req_out_n_q[0])
        else $error("request 0 not asserted in satellite mode");
    a_sat_dev_sel: assert property ($past(m_sat) |->
        !req_oe_q[1] && cfg_sel_q == $past(req_s[1]))
        else $error("device select wrong in satellite mode");
    a_sat_spare_high: assert property ($past(m_sat) |->
        req_oe_q[3:2] == 2'h3 && req_out_n_q[3:2] == 2'h3)
        else $error("spare requests not high in satellite mode");
    a_alt_req_lanes: assert property ($past(m_int) |->
        arb_req_q[5:4] == ($past(lane_en[5:4]) & ~$past(req_s[5:4])))
        else $error("extra request lanes wrong");
    a_host_reset_out: assert property ($past(m_host) |->
        rst_oe_q && rst_out_n_q == !$past(bus_reset_request))
        else $error("bus reset not driven in host mode");
    a_warm_pulse: assert property (m_sat && rst_prev_q && !rst_s |=>
        warm_reset ##1 !warm_reset)
        else $error("warm reset pulse wrong");
    a_serr_drive: assert property ($past(m_set) |->
        serr_oe_q == $past(system_error_request) && !system_error_line_n_out)
        else $error("system error drive wrong");
    a_gpio0_alt: assert property ($past(reset_n) && $past(gpio0_alt) |->
        gp_oe_q && gp_out_q == $past(serial0_transmit_out))
        else $error("pin 0 alternate output wrong");
    a_int_grant: assert property ($past(m_int) |->
        gnt_oe_q == 4'hF && gnt_out_n_q == ~$past(arb_grant))
        else $error("grant lanes wrong in internal mode");
    a_mode_static: assert property (m_set |=> $stable(mode_q))
        else $error("mode changed after strap sampling");
endmodule

// *** tb/prm_far_agent.sv ***
// Purpose: Far side of the pins: agents, arbiter, host, pull-ups
// Assumes: Released lines float to their pull-up level
// Notes: Device drive wins wherever its enable is high
`timescale 1ns/1ps
module prm_far_agent
    import prm_pkg::*;
(
    input wire logic [5:0] req_out,
    input wire logic [5:0] req_oe,
    input wire logic [5:0] agent_req,
    input wire logic ext_grant,
    input wire logic rst_out,
    input wire logic rst_oe,
    input wire logic host_rst,
    input wire logic serr_oe,
    input wire logic serr_out,
    input wire logic agent_serr,
    input wire logic gp_out,
    input wire logic gp_oe,
    input wire logic gp_val,
    output logic [5:0] req_pin,
    output logic gnt0_pin,
    output logic rst_pin,
    output logic serr_pin,
    output logic gp_pin
);
    // Agents pull lanes low; host sets lane 1 as select
    assign req_pin = (req_oe & req_out) | (~req_oe & ~agent_req);
    // External arbiter grant, active low
    assign gnt0_pin = ~ext_grant;
    // Host drives reset once the device lets go
    assign rst_pin = rst_oe ? rst_out : ~host_rst;
    // Open drain with pull-up: any party pulls low
    assign serr_pin = ~((serr_oe & ~serr_out) | agent_serr);
    // Bench drives pin 0 when the device releases it
    assign gp_pin = gp_oe ? gp_out : gp_val;
endmodule

// *** tb/pci_request_reset_pin_mux_tb.sv ***
// Purpose: Self-checking bench for the pin steering block
// Assumes: Far side modelled by prm_far_agent
// Notes: Inputs change on the falling edge; each mode needs a reset
`timescale 1ns/1ps
module pci_request_reset_pin_mux_tb
    import prm_pkg::*;
;
    logic clk = 0, reset_n = 0, sh = 1, se = 0, a4 = 0, a5 = 0;
    logic eg = 0, own = 0, brr = 0, hr = 0, ser = 0, aser = 0;
    logic g_alt = 0, g_o = 0, g_oe = 0, tx = 0, gv = 0;
    logic [5:0] areq = 0, ro, roe, arb, rpin;
    logic [3:0] ag = 0, go, goe;
    logic og, cds, rsto, rstoe, wr, so, soe, seen, gpo, gpoe, gin;
    logic gpin, rstpin, spin, g0pin, e_oe, e_o;
    logic [5:0] eo;
    logic [31:0] seed = 32'hED708358;
    int error_cnt = 0, compares = 0, wr_cnt = 0, m;

    prm_pin_mux i_dut (.clk(clk), .reset_n(reset_n), .strap_host(sh),
        .strap_ext_arb(se), .bus_request_lines_n_in(rpin),
        .bus_request_lines_n_out(ro), .bus_request_lines_n_oe(roe),
        .gpio_alt_req4(a4), .gpio_alt_req5(a5), .arb_request(arb),
        .arb_grant(ag), .bus_grant_line0_n_in(g0pin),
        .bus_grant_lines_n_out(go), .bus_grant_lines_n_oe(goe),
        .own_request(own), .own_granted(og), .config_device_select(cds),
        .bus_reset_request(brr), .bus_reset_line_n_in(rstpin),
        .bus_reset_line_n_out(rsto), .bus_reset_line_n_oe(rstoe),
        .warm_reset(wr), .system_error_request(ser),
        .system_error_line_n_in(spin), .system_error_line_n_out(so),
        .system_error_line_n_oe(soe), .system_error_seen(seen),
        .gpio0_alt(g_alt), .gpio0_out(g_o), .gpio0_oe(g_oe),
        .serial0_transmit_out(tx), .gpio0_pin_in(gpin),
        .gpio0_pin_out(gpo), .gpio0_pin_oe(gpoe), .gpio0_in(gin));

    prm_far_agent i_far (.req_out(ro), .req_oe(roe), .agent_req(areq),
        .ext_grant(eg), .rst_out(rsto), .rst_oe(rstoe), .host_rst(hr),
        .serr_oe(soe), .serr_out(so), .agent_serr(aser), .gp_out(gpo),
        .gp_oe(gpoe), .gp_val(gv), .req_pin(rpin), .gnt0_pin(g0pin),
        .rst_pin(rstpin), .serr_pin(spin), .gp_pin(gpin));

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Counts warm reset pulses, sampled mid-cycle where settled
    always @(negedge clk) begin
        if (wr === 1'b1) wr_cnt++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
    endfunction

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic conclude();
        $display("Compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Straps set while reset is held; mode 0 int, 1 ext, 2 sat
    task automatic boot(input int md);
        @(negedge clk);
        reset_n = 0;
        sh = (md != 2);
        se = (md == 1);
        repeat (12) @(negedge clk);
        cmp(8'({roe, goe[1:0]}), 8'h00);
        reset_n = 1;
        repeat (6) @(negedge clk);
    endtask

    // Two reset pin pulses; only satellite mode answers
    task automatic pulses(input int md);
        int n0;
        n0 = wr_cnt;
        repeat (2) begin
            @(negedge clk);
            hr = 1;
            brr = 1;
            repeat (4) @(negedge clk);
            hr = 0;
            brr = 0;
            repeat (4) @(negedge clk);
        end
        cmp(8'(wr_cnt - n0), md == 2 ? 8'h02 : 8'h00);
    endtask

    // Random inputs, then every steered output against the mode
    task automatic step(input int md);
        @(negedge clk);
        seed = lfsr(seed);
        {areq, a4, a5, ag, eg, own, brr, ser, aser} = seed[16:0];
        {g_alt, g_o, g_oe, tx, gv} = seed[21:17];
        repeat (4) @(posedge clk);
        #1;
        eo = {a5, a4, (md == 1) ? 4'hF : 4'hD};
        if (md == 0) begin
            cmp(8'(roe), 8'h00);
            cmp(8'(arb), 8'(areq & {a5, a4, 4'hF}));
            cmp(8'({goe, go}), {4'hF, ~ag});
        end else begin
            cmp(8'(roe), 8'(eo));
            cmp(8'(ro & eo), 8'({5'h1F, ~own} & eo));
            cmp(8'({og, arb}), {1'b0, eg, 6'h00});
            cmp(8'({goe, go[3:1]}), 8'h77);
        end
        if (md == 2) begin
            cmp(8'({cds, rstoe}), 8'({~areq[1], 1'b0}));
        end else begin
            cmp(8'({rstoe, rsto}), 8'({1'b1, ~brr}));
        end
        cmp(8'({soe, seen}), 8'({ser, ser | aser}));
        e_oe = g_alt | g_oe;
        e_o = g_alt ? tx : g_o;
        cmp(8'({gpoe, gpo & e_oe, gin}),
            8'({e_oe, e_o & e_oe, e_oe ? e_o : gv}));
    endtask

    initial begin
        for (m = 0; m < 3; m++) begin
            boot(m);
            if (m == 2) begin
                @(negedge clk);
                own = 1;
                @(posedge clk);
                #1;
                cmp(8'(ro[0]), 8'h00);
            end
            pulses(m);
            repeat (24) step(m);
            $display("Mode %0d test done", m);
        end
        conclude();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #20000;
        error_cnt++;
        conclude();
    end
endmodule
